// ### rtl/gtc_timer.sv
// Gated 16-bit timer/counter with prescaler, gate logic and buffered access.
// Assumes a byte register port; external clocks are sampled by the core clock.
//////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1: source field picks instruction, system or external
// RULE2: oscillator enable picks pin or oscillator input
// RULE3: external counting starts after first falling edge
// RULE4: prescale field divides by one to eight
// RULE5: sync bit selects synchronised external input
// RULE6: on bit enables counting, clear holds count
// RULE7: gate enable makes counting follow gate
// RULE8: polarity bit selects active high or low
// RULE9: toggle mode divides gate; clear holds flop (the code resets toggle_ff to 0 while the bit is clear)
// RULE10: single pulse mode; clearing it clears go
// RULE11: go bit reads one while armed
// RULE12: trailing edge clears go, blocks further counting
// RULE13: gate level bit always shows gate value
// RULE14: gate source field selects among four inputs
// RULE15: gate enable requests watchdog oscillator
// RULE16: software writes gate control before control
// RULE17: software avoids system clock for capture
// RULE18: byte mode accesses bytes directly
// RULE19: wide mode low read latches high byte
// RULE20: wide mode high write goes to buffer
// RULE21: low byte write clears the prescaler
// RULE22: keep running bit holds oscillator on
// RULE23: counter wraps and sets overflow flag
// RULE24: gate falling edge sets gate event flag
// RULE25: special event trigger clears the counter
//
// Decided for this implementation: the register offsets and the strobed register port.
module gtc_timer (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // Register port
  input  wire gtc_pkg::gtc_bus_t     bus,
  output logic [7:0]                 rdata,
  // External inputs
  input  wire logic                  external_count_pin,
  input  wire logic                  secondary_oscillator,
  input  wire logic                  osc_digital_input,
  input  wire gtc_pkg::gtc_gate_in_t gate_in,
  input  wire logic                  special_event,
  input  wire logic                  system_on_secondary_osc,
  input  wire logic                  mid_osc_stable,
  // Status and requests
  output logic                       overflow_flag,
  output logic                       overflow_irq,
  output logic                       gate_event_flag,
  output logic                       gate_event_irq,
  output logic                       watchdog_osc_request,
  output logic                       osc_run_request,
  output logic                       mid_osc_select
);
  import gtc_pkg::*;

  logic [7:0]     timer_control;
  logic [7:0]     timer_gate_control;
  logic           osc_keep_running;
  logic           pulse_acquire_go_done;
  logic [1:0]     irq_enable;
  logic [15:0]    count;
  logic [7:0]     high_buffer;
  logic [2:0]     prescale;
  logic [1:0]     instr_div;
  logic           ext_prev;
  gtc_ext_state_t ext_state;
  logic           toggle_ff;
  logic           gate_prev;
  logic           level_prev;
  logic           pulse_seen;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for pin-side signals
  logic pin_sync;
  logic osc_sync;
  logic dig_sync;
  logic gpin_sync;
  logic cmp1_sync;
  logic cmp2_sync;

  gtc_sync3 u_sync_pin  (.clock(clock), .resetn(resetn), .din(external_count_pin),
                         .dout(pin_sync));
  gtc_sync3 u_sync_osc  (.clock(clock), .resetn(resetn), .din(secondary_oscillator),
                         .dout(osc_sync));
  gtc_sync3 u_sync_dig  (.clock(clock), .resetn(resetn), .din(osc_digital_input),
                         .dout(dig_sync));
  gtc_sync3 u_sync_gpin (.clock(clock), .resetn(resetn), .din(gate_in.gate_pin),
                         .dout(gpin_sync));
  gtc_sync3 u_sync_c1   (.clock(clock), .resetn(resetn), .din(gate_in.comp1),
                         .dout(cmp1_sync));
  gtc_sync3 u_sync_c2   (.clock(clock), .resetn(resetn), .din(gate_in.comp2),
                         .dout(cmp2_sync));

  //////////////////////////////////////////////////////////////////////////////
  // Control fields
  wire [1:0] count_source_select   = timer_control[7:6];
  wire [1:0] input_prescale_select = timer_control[5:4];
  wire       secondary_osc_enable  = timer_control[GTC_BIT_SECONDARY_OSCILLATOR_EN];
  wire       external_sync_disable = timer_control[GTC_BIT_NOSYNC];
  wire       wide_access_mode      = timer_control[GTC_BIT_WIDE];
  wire       counter_on            = timer_control[GTC_BIT_ON];
  wire       gate_enable           = timer_gate_control[GTC_BIT_GE];
  wire       gate_polarity         = timer_gate_control[GTC_BIT_GPOL];
  wire       gate_toggle_mode      = timer_gate_control[GTC_BIT_GTM];
  wire       gate_single_pulse_mode = timer_gate_control[GTC_BIT_GSPM];
  wire [1:0] gate_source_select    = timer_gate_control[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Count clock selection
  // The sync bit cannot truly bypass sampling in a one-clock design; when set the
  // oscillator path takes the digital oscillator input through its own synchroniser,
  // with the same agreement filtering as the other inputs; the pin path is unchanged.
  wire ext_pick_sync = secondary_osc_enable ? osc_sync : pin_sync;      // [RULE2]
  wire ext_pick_raw  = secondary_osc_enable ? dig_sync : pin_sync;      // [RULE2]
  wire ext_level     = external_sync_disable ? ext_pick_raw : ext_pick_sync; // [RULE5]
  wire ext_rise      = ext_level & ~ext_prev;
  wire ext_fall      = ~ext_level & ext_prev;
  wire ext_tick      = ext_rise && (ext_state == GTC_EXT_ARMED);        // [RULE3]
  wire instr_tick    = (instr_div == GTC_INSTR_DIV_LAST);

  logic src_tick;
  always_comb begin
    case (count_source_select)                                          // [RULE1]
      GTC_SRC_INSTR: src_tick = instr_tick;
      GTC_SRC_SYS:   src_tick = 1'b1;
      GTC_SRC_EXT:   src_tick = ext_tick;
      default:       src_tick = ext_tick;
    endcase
  end

  function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
    prescale_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction : prescale_mask

  wire [2:0] ps_mask  = prescale_mask(input_prescale_select);
  wire       ps_tick  = src_tick && ((prescale & ps_mask) == ps_mask);  // [RULE4]

  //////////////////////////////////////////////////////////////////////////////
  // Gate path
  logic gate_raw;
  always_comb begin
    case (gate_source_select)                                           // [RULE14]
      2'h0:    gate_raw = gpin_sync;
      2'h1:    gate_raw = gate_in.partner_match;
      2'h2:    gate_raw = cmp1_sync;
      default: gate_raw = cmp2_sync;
    endcase
  end

  wire gate_pol    = gate_polarity ? gate_raw : ~gate_raw;             // [RULE8]
  wire gate_rise   = gate_pol & ~gate_prev;
  wire gate_tog    = gate_toggle_mode ? toggle_ff : gate_pol;          // [RULE9]
  wire gate_level  = gate_single_pulse_mode ?
                     (gate_tog & pulse_acquire_go_done & pulse_seen) : gate_tog; // [RULE12]
  logic level_prev_tog;
  wire level_fall  = ~gate_level & level_prev;
  wire tog_rise    = gate_tog & ~level_prev_tog;

  wire count_en    = counter_on && (!gate_enable || gate_level);       // [RULE6] [RULE7]
  wire count_step  = count_en && ps_tick;
  wire wrap        = count_step && (count == 16'hFFFF);                // [RULE23]

  //////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_ctrl  = bus.wr && (bus.addr == GTC_ADDR_CONTROL);
  wire wr_gate  = bus.wr && (bus.addr == GTC_ADDR_GATE);
  wire wr_osc   = bus.wr && (bus.addr == GTC_ADDR_OSC);
  wire wr_low   = bus.wr && (bus.addr == GTC_ADDR_LOW);
  wire wr_high  = bus.wr && (bus.addr == GTC_ADDR_HIGH);
  wire wr_flags = bus.wr && (bus.addr == GTC_ADDR_FLAGS);
  wire rd_low   = bus.rd && (bus.addr == GTC_ADDR_LOW);
  wire go_set   = wr_gate && bus.wdata[GTC_BIT_GO] && bus.wdata[GTC_BIT_GSPM];
  wire go_clear = (wr_gate && !bus.wdata[GTC_BIT_GSPM])                // [RULE10]
                  || (gate_single_pulse_mode && pulse_seen && level_fall); // [RULE12]

  wire [7:0] gate_readback = {timer_gate_control[7:4], pulse_acquire_go_done,
                              gate_level, timer_gate_control[1:0]};     // [RULE11] [RULE13]
  wire [7:0] osc_readback  = {1'b0, system_on_secondary_osc, 2'b00, osc_keep_running,
                              1'b0, mid_osc_stable, mid_osc_select};
  wire [7:0] high_readback = wide_access_mode ? high_buffer : count[15:8]; // [RULE18]

  logic [7:0] next_rdata;
  always_comb begin
    case (bus.addr)
      GTC_ADDR_CONTROL: next_rdata = timer_control;
      GTC_ADDR_GATE:    next_rdata = gate_readback;
      GTC_ADDR_OSC:     next_rdata = osc_readback;
      GTC_ADDR_LOW:     next_rdata = count[7:0];
      GTC_ADDR_HIGH:    next_rdata = high_readback;
      GTC_ADDR_FLAGS:   next_rdata = {4'h0, irq_enable, gate_event_flag, overflow_flag};
      default:          next_rdata = 8'h00;
    endcase
  end

  // Low write in wide mode loads the buffered high byte and the written low byte at once
  wire [15:0] write_value = wide_access_mode ? {high_buffer, bus.wdata}   // [RULE20]
                                             : {count[15:8], bus.wdata};  // [RULE18]
  wire        direct_high = wr_high && !wide_access_mode;                 // [RULE18]

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_control      <= GTC_CONTROL_RESET;
      timer_gate_control <= GTC_GATE_RESET;
      osc_keep_running   <= 1'b0;
      mid_osc_select     <= 1'b0;
      irq_enable         <= 2'b00;
      rdata              <= 8'h00;
    end else begin
      rdata <= bus.rd ? next_rdata : 8'h00;
      if (wr_ctrl) begin
        timer_control <= bus.wdata;
      end
      if (wr_gate) begin
        timer_gate_control <= bus.wdata;
      end
      if (wr_osc) begin
        osc_keep_running <= bus.wdata[GTC_BIT_KEEP_RUN];
        mid_osc_select   <= bus.wdata[GTC_BIT_MID_SEL];
      end
      if (wr_flags) begin
        irq_enable <= bus.wdata[3:2];
      end
    end
  end

  // Go bit: hardware completion wins nothing over software arming in one cycle;
  // arming in the completion cycle keeps the capture armed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulse_acquire_go_done <= 1'b0;
      pulse_seen            <= 1'b0;
    end else begin
      if (go_set) begin
        pulse_acquire_go_done <= 1'b1;                                  // [RULE11]
        pulse_seen            <= 1'b0;
      end else if (go_clear) begin
        pulse_acquire_go_done <= 1'b0;                                  // [RULE10] [RULE12]
        pulse_seen            <= 1'b0;
      end else if (pulse_acquire_go_done && tog_rise) begin
        pulse_seen <= 1'b1;
      end
    end
  end

  // Counter, buffer and prescaler
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count       <= 16'h0000;
      high_buffer <= 8'h00;
      prescale    <= 3'h0;
    end else begin
      if (special_event) begin
        count <= 16'h0000;                                              // [RULE25]
      end else if (wr_low) begin
        count <= write_value;                                           // [RULE20]
      end else if (direct_high) begin
        count <= {bus.wdata, count[7:0]};
      end else if (count_step) begin
        count <= count + 16'h0001;                                      // [RULE23]
      end
      if (wr_high && wide_access_mode) begin
        high_buffer <= bus.wdata;                                       // [RULE20]
      end else if (rd_low && wide_access_mode) begin
        high_buffer <= count[15:8];                                     // [RULE19]
      end
      if (wr_low) begin
        prescale <= 3'h0;                                               // [RULE21]
      end else if (count_en && src_tick) begin
        prescale <= prescale + 3'h1;
      end
    end
  end

  // Clock dividers, edge trackers and gate flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      instr_div      <= 2'h0;
      ext_prev       <= 1'b0;
      ext_state      <= GTC_EXT_WAIT_LOW;
      gate_prev      <= 1'b0;
      toggle_ff      <= 1'b0;
      level_prev     <= 1'b0;
      level_prev_tog <= 1'b0;
    end else begin
      instr_div      <= instr_div + 2'h1;
      ext_prev       <= ext_level;
      gate_prev      <= gate_pol;
      level_prev     <= gate_level;
      level_prev_tog <= gate_tog;
      if (wr_ctrl) begin
        ext_state <= GTC_EXT_WAIT_LOW;
      end else if (ext_fall) begin
        ext_state <= GTC_EXT_ARMED;                                     // [RULE3]
      end
      if (!gate_toggle_mode) begin
        toggle_ff <= 1'b0;                                              // [RULE9]
      end else if (gate_rise) begin
        toggle_ff <= ~toggle_ff;                                        // [RULE9]
      end
    end
  end

  // Flags: a hardware set in the clear cycle wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      overflow_flag        <= 1'b0;
      gate_event_flag      <= 1'b0;
      overflow_irq         <= 1'b0;
      gate_event_irq       <= 1'b0;
      watchdog_osc_request <= 1'b0;
      osc_run_request      <= 1'b0;
    end else begin
      if (wrap) begin
        overflow_flag <= 1'b1;                                          // [RULE23]
      end else if (wr_flags && !bus.wdata[0]) begin
        overflow_flag <= 1'b0;
      end
      if (level_fall) begin
        gate_event_flag <= 1'b1;                                        // [RULE24]
      end else if (wr_flags && !bus.wdata[1]) begin
        gate_event_flag <= 1'b0;
      end
      overflow_irq         <= overflow_flag & irq_enable[0];            // [RULE23]
      gate_event_irq       <= gate_event_flag & irq_enable[1];
      watchdog_osc_request <= gate_enable;                              // [RULE15]
      osc_run_request      <= osc_keep_running ||                       // [RULE22]
                              (secondary_osc_enable && count_source_select == GTC_SRC_EXT);
    end
  end
endmodule : gtc_timer

// ### shared/gtc_pkg.sv
// Package for the gated 16-bit timer/counter: register map, fields, reset values.
// Assumes a byte-wide register port with a 3-bit address.
package gtc_pkg;

  localparam logic [2:0] GTC_ADDR_CONTROL = 3'h0;
  localparam logic [2:0] GTC_ADDR_GATE    = 3'h1;
  localparam logic [2:0] GTC_ADDR_OSC     = 3'h2;
  localparam logic [2:0] GTC_ADDR_LOW     = 3'h3;
  localparam logic [2:0] GTC_ADDR_HIGH    = 3'h4;
  localparam logic [2:0] GTC_ADDR_FLAGS   = 3'h5;

  localparam logic [7:0] GTC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] GTC_GATE_RESET    = 8'h00;
  localparam logic [7:0] GTC_OSC_RESET     = 8'h00;

  localparam int GTC_BIT_ON       = 0;
  localparam int GTC_BIT_WIDE     = 1;
  localparam int GTC_BIT_NOSYNC   = 2;
  localparam int GTC_BIT_SECONDARY_OSCILLATOR_EN  = 3;
  localparam int GTC_BIT_GE       = 7;
  localparam int GTC_BIT_GPOL     = 6;
  localparam int GTC_BIT_GTM      = 5;
  localparam int GTC_BIT_GSPM     = 4;
  localparam int GTC_BIT_GO       = 3;
  localparam int GTC_BIT_GVAL     = 2;
  localparam int GTC_BIT_KEEP_RUN = 3;
  localparam int GTC_BIT_SYS_SECONDARY_OSCILLATOR = 6;
  localparam int GTC_BIT_MID_STBL = 1;
  localparam int GTC_BIT_MID_SEL  = 0;

  localparam logic [1:0] GTC_SRC_INSTR = 2'h0;
  localparam logic [1:0] GTC_SRC_SYS   = 2'h1;
  localparam logic [1:0] GTC_SRC_EXT   = 2'h2;

  localparam logic [1:0] GTC_INSTR_DIV_LAST = 2'h3;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gtc_bus_t;

  typedef struct packed {
    logic gate_pin;
    logic partner_match;
    logic comp1;
    logic comp2;
  } gtc_gate_in_t;

  typedef enum logic [1:0] {
    GTC_EXT_WAIT_LOW = 2'b00,
    GTC_EXT_ARMED    = 2'b01
  } gtc_ext_state_t;

endpackage : gtc_pkg

// ### rtl/gtc_sync3.sv
// Three-flop synchroniser with agreement filter for one asynchronous input.
// Assumes the input is asynchronous to clock.
module gtc_sync3 (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Signal
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      // A change counts only once the later two stages agree
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule : gtc_sync3

// ### verif/gtc_asserts.sv
// Port checker for the gated 16-bit timer/counter.
// Assumes the register map and latencies of the timer package; bound below.
module gtc_asserts import gtc_pkg::*; (
  // Clock and reset
  input wire logic              clock,
  input wire logic              resetn,
  // Register port
  input wire gtc_pkg::gtc_bus_t bus,
  input wire logic [7:0]        rdata,
  // Status and requests
  input wire logic              overflow_flag,
  input wire logic              overflow_irq,
  input wire logic              gate_event_flag,
  input wire logic              gate_event_irq,
  input wire logic              watchdog_osc_request,
  input wire logic              osc_run_request
);
  logic wr_g;
  logic wr_o;
  logic wr_c;
  logic rd_c;
  logic wr_f;
  assign wr_g = bus.wr && bus.addr == GTC_ADDR_GATE;
  assign wr_o = bus.wr && bus.addr == GTC_ADDR_OSC;
  assign wr_c = bus.wr && bus.addr == GTC_ADDR_CONTROL;
  assign rd_c = bus.rd && bus.addr == GTC_ADDR_CONTROL;
  assign wr_f = bus.wr && bus.addr == GTC_ADDR_FLAGS;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (
    !$past(bus.rd) |-> rdata == 8'h00) else $error("read data not idle");
  AST_RD_HOLE: assert property (
    $past(bus.rd) && $past(bus.addr) > 3'h5 |-> rdata == 8'h00) else $error("hole read not zero");
  AST_CTRL_BACK: assert property (
    wr_c ##1 !bus.wr ##1 rd_c |=> rdata == $past(bus.wdata, 3)) else $error("control readback");
  AST_WDOG_REQ: assert property (
    wr_g ##1 !wr_g |=> watchdog_osc_request == $past(bus.wdata[7], 2)) else $error("watchdog req");
  AST_OSC_RUN: assert property (
    wr_o && bus.wdata[GTC_BIT_KEEP_RUN] |-> ##2 osc_run_request) else $error("osc run req");
  AST_OVF_IRQ: assert property (
    overflow_irq |-> $past(overflow_flag)) else $error("overflow irq without flag");
  AST_GEV_IRQ: assert property (
    gate_event_irq |-> $past(gate_event_flag)) else $error("gate irq without flag");
  AST_OVF_STICKY: assert property (
    $fell(overflow_flag) |-> $past(wr_f && !bus.wdata[0])) else $error("overflow flag lost");
  AST_GEV_STICKY: assert property (
    $fell(gate_event_flag) |-> $past(wr_f && !bus.wdata[1])) else $error("gate flag lost");
  cover property ($rose(overflow_flag));
  cover property ($rose(gate_event_flag));
  cover property ($rose(watchdog_osc_request));
endmodule : gtc_asserts

bind gtc_timer gtc_asserts chk_u (
  .clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata),
  .overflow_flag(overflow_flag), .overflow_irq(overflow_irq),
  .gate_event_flag(gate_event_flag), .gate_event_irq(gate_event_irq),
  .watchdog_osc_request(watchdog_osc_request), .osc_run_request(osc_run_request)
);

// ### verif/gtc_ext_model.sv
// Far-side count sources: external count pin and secondary oscillator line.
// Assumes the bench asks for pulse trains; both lines idle low between them.
module gtc_ext_model (
  // Clock
  input wire logic clock,
  // Count sources
  output logic     pin_o,
  output logic     osc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl = 1'b0;
  logic sel = 1'b0;
  // Only the chosen line moves, so a wrong source pick shows as no count
  assign pin_o = lvl && !sel;
  assign osc_o = lvl && sel;
  task automatic pulse(input int n, input logic use_osc);
    sel = use_osc;
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge clock);
      #3 lvl = 1'b1;
      repeat (6) @(posedge clock);
      #3 lvl = 1'b0;
    end
  endtask : pulse
endmodule : gtc_ext_model

// ### verif/tb.sv
// Self-checking bench for the gated 16-bit timer/counter.
// Assumes the byte register port of the timer package, one core clock.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gtc_pkg::*;
  logic         clock = 1'b0;
  logic         resetn;
  gtc_bus_t     bus;
  gtc_gate_in_t gin;
  logic [7:0]   rdata;
  logic [3:0]   sel;
  logic         pin, osc, sev, stat, ovf, ovf_irq, gev, gev_irq, wdog, run, msel;
  int           err_total = 0;
  int           tests_run = 0;
  always #5 clock = ~clock;
  gtc_ext_model ext_u (.clock(clock), .pin_o(pin), .osc_o(osc));
  gtc_timer dut_u (
    .clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata),
    .external_count_pin(pin), .secondary_oscillator(osc), .osc_digital_input(osc),
    .gate_in(gin), .special_event(sev), .system_on_secondary_osc(stat),
    .mid_osc_stable(stat), .overflow_flag(ovf), .overflow_irq(ovf_irq),
    .gate_event_flag(gev), .gate_event_irq(gev_irq), .watchdog_osc_request(wdog),
    .osc_run_request(run), .mid_osc_select(msel)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Counts sampled against a free clock differ by phase, hence the margin
  task automatic near(input string n, input int e, input logic [7:0] g);
    tests_run++;
    if ($isunknown(g) || g > e + 2 || g + 2 < e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %h", n, e, g);
    end
  endtask : near
  task automatic rd_chk(input string n, input logic [2:0] a, input logic [7:0] e,
                        input logic [7:0] m);
    logic [7:0] d;
    reg_rd(a, d);
    chk(n, e & m, d & m);
  endtask : rd_chk
  // In wide mode the high write lands in the buffer, the low write commits both
  task automatic load(input logic [15:0] v);
    reg_wr(GTC_ADDR_HIGH, v[15:8]);
    reg_wr(GTC_ADDR_LOW, v[7:0]);
  endtask : load
  function automatic int rate(input int w, input int div, input logic [1:0] ps);
    return w / (div << ps);
  endfunction : rate
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200_000;
    err_total++;
    tally_and_finish();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] c;
    logic [7:0] d;
    bus = '0;
    gin = '0;
    sev = 1'b0;
    stat = 1'b1;
    resetn = 1'b0;
    sel = 4'h0;
    void'($urandom(64100));
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd_chk("control", GTC_ADDR_CONTROL, GTC_CONTROL_RESET, 8'hFF);
    rd_chk("gate", GTC_ADDR_GATE, GTC_GATE_RESET, 8'hFB);
    rd_chk("osc", GTC_ADDR_OSC, 8'h42, 8'hFF);
    rd_chk("hole", 3'h6, 8'h00, 8'hFF);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      reg_wr(GTC_ADDR_GATE, d);
      rd_chk("gate", GTC_ADDR_GATE, d, 8'hF3);
      chk("wdog", {7'h00, d[7]}, {7'h00, wdog});
      d = 8'($urandom);
      d[7] = d[7] & ~d[6];
      reg_wr(GTC_ADDR_CONTROL, d);
      rd_chk("control", GTC_ADDR_CONTROL, d, 8'hFF);
    end
    reg_wr(GTC_ADDR_GATE, 8'h00);
    reg_wr(GTC_ADDR_CONTROL, 8'h00);
    $display("test readback done");
    c = 8'($urandom);
    d = 8'($urandom);
    load({c, d});
    rd_chk("low", GTC_ADDR_LOW, d, 8'hFF);
    rd_chk("high", GTC_ADDR_HIGH, c, 8'hFF);
    reg_wr(GTC_ADDR_CONTROL, 8'h02);
    load({~c, ~d});
    rd_chk("low", GTC_ADDR_LOW, ~d, 8'hFF);
    reg_wr(GTC_ADDR_HIGH, c);
    rd_chk("low", GTC_ADDR_LOW, ~d, 8'hFF);
    rd_chk("high", GTC_ADDR_HIGH, ~c, 8'hFF);
    $display("test access done");
    for (int m = 0; m < 8; m++) begin
      reg_wr(GTC_ADDR_CONTROL, 8'h00);
      load(16'h0000);
      reg_wr(GTC_ADDR_CONTROL, {1'b0, m[2], m[1:0], 4'b0001});
      repeat (128) @(posedge clock);
      reg_rd(GTC_ADDR_LOW, d);
      near("rate", rate(130, m[2] ? 1 : 4, m[1:0]), d);
    end
    reg_wr(GTC_ADDR_CONTROL, 8'h00);
    reg_rd(GTC_ADDR_LOW, c);
    repeat (20) @(posedge clock);
    rd_chk("hold", GTC_ADDR_LOW, c, 8'hFF);
    $display("test rate done");
    for (int m = 0; m < 4; m++) begin
      reg_wr(GTC_ADDR_CONTROL, 8'h00);
      load(16'h0000);
      reg_wr(GTC_ADDR_CONTROL, {4'b1000, m[1], m[0], 2'b01});
      ext_u.pulse(5, m[1]);
      repeat (8) @(posedge clock);
      rd_chk("ext", GTC_ADDR_LOW, 8'h04, 8'hFF);
      chk("run", {7'h00, m[1]}, {7'h00, run});
    end
    $display("test external done");
    reg_wr(GTC_ADDR_FLAGS, 8'h0C);
    for (int s = 0; s < 4; s++) begin
      sel = 4'b1000 >> s;
      reg_wr(GTC_ADDR_CONTROL, 8'h00);
      reg_wr(GTC_ADDR_GATE, {1'b1, s[0], 4'h0, s[1:0]});
      // Gate inputs settle through their synchronisers before the timer is switched on
      gin <= gtc_gate_in_t'(s[0] ? ~sel : sel);
      load(16'h0000);
      reg_wr(GTC_ADDR_CONTROL, 8'h01);
      repeat (64) @(posedge clock);
      rd_chk("gated", GTC_ADDR_LOW, 8'h00, 8'hFF);
      load(16'h0000);
      gin <= gtc_gate_in_t'(~gin);
      repeat (64) @(posedge clock);
      reg_rd(GTC_ADDR_LOW, d);
      near("gated", rate(64, 4, 2'd0), d);
      rd_chk("level", GTC_ADDR_GATE, 8'h04, 8'h04);
      reg_wr(GTC_ADDR_FLAGS, 8'h0C);
      @(posedge clock);
      chk("gev", 8'h00, {7'h00, gev});
      gin <= gtc_gate_in_t'(~gin);
      repeat (8) @(posedge clock);
      chk("gev", 8'h01, {7'h00, gev});
      chk("gev_irq", 8'h01, {7'h00, gev_irq});
    end
    $display("test gate done");
    reg_wr(GTC_ADDR_CONTROL, 8'h00);
    gin <= '0;
    load(16'h0000);
    reg_wr(GTC_ADDR_GATE, 8'hD8);
    reg_wr(GTC_ADDR_CONTROL, 8'h01);
    rd_chk("armed", GTC_ADDR_GATE, 8'h08, 8'h08);
    for (int p = 0; p < 2; p++) begin
      gin.gate_pin <= 1'b1;
      repeat (40) @(posedge clock);
      gin.gate_pin <= 1'b0;
      repeat (8) @(posedge clock);
    end
    rd_chk("done", GTC_ADDR_GATE, 8'h00, 8'h08);
    reg_rd(GTC_ADDR_LOW, d);
    near("pulse", rate(40, 4, 2'd0), d);
    reg_wr(GTC_ADDR_GATE, 8'hD8);
    reg_wr(GTC_ADDR_GATE, 8'hC8);
    rd_chk("disarm", GTC_ADDR_GATE, 8'h00, 8'h08);
    // Toggle flop keeps the gate high after the pin has dropped again
    reg_wr(GTC_ADDR_GATE, 8'h60);
    gin.gate_pin <= 1'b1;
    repeat (8) @(posedge clock);
    gin.gate_pin <= 1'b0;
    repeat (8) @(posedge clock);
    rd_chk("toggle", GTC_ADDR_GATE, 8'h04, 8'h04);
    $display("test pulse done");
    reg_wr(GTC_ADDR_GATE, 8'h00);
    reg_wr(GTC_ADDR_CONTROL, 8'h00);
    load(16'hFFF0);
    reg_wr(GTC_ADDR_FLAGS, 8'h0C);
    reg_wr(GTC_ADDR_CONTROL, 8'h41);
    repeat (30) @(posedge clock);
    reg_wr(GTC_ADDR_CONTROL, 8'h00);
    chk("ovf", 8'h01, {7'h00, ovf});
    chk("ovf_irq", 8'h01, {7'h00, ovf_irq});
    rd_chk("wrap", GTC_ADDR_HIGH, 8'h00, 8'hFF);
    reg_wr(GTC_ADDR_FLAGS, 8'h0C);
    @(posedge clock);
    chk("ovf", 8'h00, {7'h00, ovf});
    load(16'h1234);
    @(posedge clock);
    sev <= 1'b1;
    @(posedge clock);
    sev <= 1'b0;
    rd_chk("trigger", GTC_ADDR_LOW, 8'h00, 8'hFF);
    rd_chk("trigger", GTC_ADDR_HIGH, 8'h00, 8'hFF);
    reg_wr(GTC_ADDR_OSC, 8'h09);
    repeat (3) @(posedge clock);
    chk("run", 8'h01, {7'h00, run});
    chk("msel", 8'h01, {7'h00, msel});
    $display("test misc done");
    tally_and_finish();
  end
endmodule : tb
